//--- core/synth_serial_program_port.sv
// Serial programming port of a dual synthesiser with an AXI4-Lite register view
`timescale 1ns/10ps
module synth_serial_program_port #(
	parameter int ADDR_W = 8
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic sclk_pin,
	input wire logic sdata_pin,
	input wire logic strobe_pin,
	input wire logic cmp_tick,
	output synth_prog_pkg::main_s main_cfg,
	output synth_prog_pkg::setup_s setup_cfg,
	output logic [11:0] aux_divider,
	output synth_prog_pkg::ref_s ref_cfg,
	output logic [7:0] second_ratio_count,
	output logic [3:0] third_ratio_count,
	output logic [3:0] fourth_ratio_count,
	output logic [3:0] main_ref_mult,
	output logic [3:0] aux_ref_mult,
	output logic main_standby,
	output logic aux_standby,
	output logic speedup,
	output logic [4:0] prop_gain,
	output logic [4:0] comp_gain,
	output logic integral_pump,
	output logic integral_cancel_pulse,
	output logic [3:0] integral_scale,
	output logic [3:0] frac_acc,
	output logic ratio_plus_one
);
	logic [synth_prog_pkg::PIN_COUNT-1:0] pin_meta_reg;
	logic [synth_prog_pkg::PIN_COUNT-1:0] pin_sync_reg;
	logic [synth_prog_pkg::PIN_COUNT-1:0] pin_last_reg;
	logic sclk_rise;
	logic stb_rise;
	logic stb_high;
	logic link_en_reg;
	logic [synth_prog_pkg::LONG_BITS-1:0] shift_reg;
	synth_prog_pkg::kind_e kind;
	synth_prog_pkg::main_word_s main_word;
	synth_prog_pkg::setup_word_s setup_word;
	synth_prog_pkg::aux_word_s aux_word;
	synth_prog_pkg::ref_word_s ref_word;
	synth_prog_pkg::setup_s hold_reg;
	logic hold_pending_reg;
	synth_prog_pkg::kind_e last_kind_reg;
	logic [3:0] frac_mod;
	logic [4:0] frac_sum;
	logic [4:0] speed_gain;
	logic aw_hold_reg;
	logic w_hold_reg;
	logic [ADDR_W-1:0] aw_addr_reg;
	logic [31:0] w_data_reg;
	logic [3:0] w_strb_reg;
	logic [31:0] rd_data;
	logic rd_ok;

	// Word type from its leading bits
	function automatic synth_prog_pkg::kind_e word_kind(
		input logic [synth_prog_pkg::LONG_BITS-1:0] sr
	);
		synth_prog_pkg::kind_e k;
		k = synth_prog_pkg::KIND_NONE;
		if (!sr[0])
		begin
			k = synth_prog_pkg::KIND_MAIN;
		end
		else if (sr[3:0] == synth_prog_pkg::PFX_SETUP)
		begin
			k = synth_prog_pkg::KIND_SETUP;
		end
		else if (sr[3:0] == synth_prog_pkg::PFX_AUX)
		begin
			k = synth_prog_pkg::KIND_AUX;
		end
		else if (sr[3:0] == synth_prog_pkg::PFX_REF)
		begin
			k = synth_prog_pkg::KIND_REF;
		end
		return k;
	endfunction

	// Reference rate multiple for a source code
	function automatic logic [3:0] src_mult(input logic [1:0] code);
		return 4'h1 << code;
	endfunction

	// Two-flop synchronisers on the three link pins
	genvar gi;
	generate
		for (gi = 0; gi < synth_prog_pkg::PIN_COUNT; gi++)
		begin : g_sync
			always_ff @(posedge aclk)
			begin
				if (!aresetn)
				begin
					pin_meta_reg[gi] <= 1'b0;
					pin_sync_reg[gi] <= 1'b0;
					pin_last_reg[gi] <= 1'b0;
				end
				else
				begin
					pin_meta_reg[gi] <= gi == synth_prog_pkg::PIN_SCLK ? sclk_pin
						: gi == synth_prog_pkg::PIN_DATA ? sdata_pin : strobe_pin;
					pin_sync_reg[gi] <= pin_meta_reg[gi];
					pin_last_reg[gi] <= pin_sync_reg[gi];
				end
			end
		end
	endgenerate

	assign stb_high = pin_sync_reg[synth_prog_pkg::PIN_STB];
	assign sclk_rise = pin_sync_reg[synth_prog_pkg::PIN_SCLK]
		& ~pin_last_reg[synth_prog_pkg::PIN_SCLK];
	assign stb_rise = stb_high & ~pin_last_reg[synth_prog_pkg::PIN_STB];
	assign kind = word_kind(shift_reg);
	assign main_word = synth_prog_pkg::main_word_s'(shift_reg);
	assign setup_word = synth_prog_pkg::setup_word_s'(shift_reg[synth_prog_pkg::SHORT_BITS-1:0]);
	assign aux_word = synth_prog_pkg::aux_word_s'(shift_reg[synth_prog_pkg::SHORT_BITS-1:0]);
	assign ref_word = synth_prog_pkg::ref_word_s'(shift_reg[synth_prog_pkg::SHORT_BITS-1:0]);

	// Input shift register, last bit received lands at bit 0
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			shift_reg <= '0;
		end
		else if (link_en_reg && sclk_rise && !stb_high)
		begin
			shift_reg <= {shift_reg[synth_prog_pkg::LONG_BITS-2:0],
				pin_sync_reg[synth_prog_pkg::PIN_DATA]};
		end
	end

	// Main word and setup transfer
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			main_cfg <= '0;
			setup_cfg <= '0;
			hold_reg <= '0;
			hold_pending_reg <= 1'b0;
		end
		else if (link_en_reg && stb_rise)
		begin
			if (kind == synth_prog_pkg::KIND_SETUP)
			begin
				hold_reg <= setup_word.body;
				hold_pending_reg <= 1'b1;
			end
			else if (kind == synth_prog_pkg::KIND_MAIN)
			begin
				main_cfg <= main_word.body;
				hold_pending_reg <= 1'b0;
				if (hold_pending_reg)
				begin
					setup_cfg <= hold_reg;
				end
				if (ref_cfg.long_sel)
				begin
					setup_cfg.current_scale <= main_word.current_scale;
				end
				else if (hold_pending_reg)
				begin
					setup_cfg.current_scale <= hold_reg.current_scale;
				end
			end
		end
	end

	// Aux and reference words
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aux_divider <= '0;
			ref_cfg <= '0;
			last_kind_reg <= synth_prog_pkg::KIND_NONE;
		end
		else if (link_en_reg && stb_rise)
		begin
			last_kind_reg <= kind;
			if (kind == synth_prog_pkg::KIND_AUX)
			begin
				aux_divider <= aux_word.aux_divider;
			end
			else if (kind == synth_prog_pkg::KIND_REF)
			begin
				ref_cfg <= ref_word.body;
			end
		end
	end

	// Prescaler ratio counts from the packed fields
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			second_ratio_count <= '0;
			third_ratio_count <= '0;
			fourth_ratio_count <= '0;
		end
		else
		begin
			case (setup_cfg.modulus_count_sel)
				synth_prog_pkg::MODS_TWO:
				begin
					second_ratio_count <= main_cfg.second_field;
					third_ratio_count <= '0;
					fourth_ratio_count <= '0;
				end
				synth_prog_pkg::MODS_THREE:
				begin
					second_ratio_count <= {4'h0, main_cfg.second_field[7:4]};
					third_ratio_count <= main_cfg.second_field[3:0]
						- main_cfg.second_field[7:4];
					fourth_ratio_count <= '0;
				end
				synth_prog_pkg::MODS_FOUR:
				begin
					second_ratio_count <= {4'h0, main_cfg.second_field[7:4]};
					third_ratio_count <= main_cfg.second_field[3:0]
						- main_cfg.second_field[7:4];
					fourth_ratio_count <= setup_cfg.ratio_sum
						- main_cfg.second_field[3:0];
				end
				default:
				begin
					second_ratio_count <= main_cfg.second_field;
					third_ratio_count <= '0;
					fourth_ratio_count <= '0;
				end
			endcase
		end
	end

	// Reference rates and standby
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			main_ref_mult <= 4'h1;
			aux_ref_mult <= 4'h1;
			main_standby <= 1'b0;
			aux_standby <= 1'b0;
		end
		else
		begin
			main_ref_mult <= src_mult(ref_cfg.main_source_sel);
			aux_ref_mult <= src_mult(ref_cfg.aux_source_sel);
			main_standby <= ref_cfg.main_off;
			aux_standby <= ref_cfg.aux_off;
		end
	end

	// Speed-up mode and pump levels
	// Three-bit shift count so that L of 3 reaches sixteen
	assign speed_gain = synth_prog_pkg::GAIN_UNITY << ({1'b0, setup_cfg.prop_accel} + 3'h1);

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			speedup <= 1'b0;
		end
		else if (!stb_high)
		begin
			speedup <= 1'b0;
		end
		else if (link_en_reg && stb_rise && kind == synth_prog_pkg::KIND_MAIN)
		begin
			speedup <= 1'b1;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			prop_gain <= synth_prog_pkg::GAIN_UNITY;
			comp_gain <= synth_prog_pkg::GAIN_UNITY;
			integral_pump <= 1'b0;
			integral_cancel_pulse <= 1'b0;
			integral_scale <= '0;
		end
		else
		begin
			prop_gain <= speedup ? speed_gain : synth_prog_pkg::GAIN_UNITY;
			comp_gain <= speedup ? speed_gain : synth_prog_pkg::GAIN_UNITY;
			integral_pump <= speedup;
			integral_cancel_pulse <= speedup;
			integral_scale <= speedup ? setup_cfg.int_accel : 4'h0;
		end
	end

	// Fractional accumulator
	assign frac_mod = ref_cfg.frac_modulus_sel ? synth_prog_pkg::FRAC_MOD8
		: synth_prog_pkg::FRAC_MOD5;
	assign frac_sum = {1'b0, frac_acc} + {2'h0, main_cfg.frac_increment};

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			frac_acc <= '0;
			ratio_plus_one <= 1'b0;
		end
		else
		begin
			ratio_plus_one <= 1'b0;
			if (cmp_tick)
			begin
				if (frac_sum >= {1'b0, frac_mod})
				begin
					frac_acc <= 4'(frac_sum - {1'b0, frac_mod});
					ratio_plus_one <= 1'b1;
				end
				else
				begin
					frac_acc <= frac_sum[3:0];
				end
			end
		end
	end

	// AXI4-Lite write channel
	assign s_axi_awready = !aw_hold_reg && !s_axi_bvalid;
	assign s_axi_wready = !w_hold_reg && !s_axi_bvalid;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_hold_reg <= 1'b0;
			w_hold_reg <= 1'b0;
			aw_addr_reg <= '0;
			w_data_reg <= '0;
			w_strb_reg <= '0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= synth_prog_pkg::RESP_OKAY;
			link_en_reg <= synth_prog_pkg::CTRL_EN_RESET;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_hold_reg <= 1'b1;
				aw_addr_reg <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_hold_reg <= 1'b1;
				w_data_reg <= s_axi_wdata;
				w_strb_reg <= s_axi_wstrb;
			end
			if (aw_hold_reg && w_hold_reg)
			begin
				aw_hold_reg <= 1'b0;
				w_hold_reg <= 1'b0;
				s_axi_bvalid <= 1'b1;
				if (aw_addr_reg == synth_prog_pkg::ADDR_CTRL)
				begin
					s_axi_bresp <= synth_prog_pkg::RESP_OKAY;
					if (w_strb_reg[0])
					begin
						link_en_reg <= w_data_reg[0];
					end
				end
				else
				begin
					s_axi_bresp <= synth_prog_pkg::RESP_SLVERR;
				end
			end
			if (s_axi_bvalid && s_axi_bready)
			begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// AXI4-Lite read channel
	always_comb
	begin
		rd_ok = 1'b1;
		rd_data = '0;
		case (s_axi_araddr)
			synth_prog_pkg::ADDR_CTRL: rd_data = {31'h0, link_en_reg};
			synth_prog_pkg::ADDR_MAIN: rd_data = {9'h0, main_cfg};
			synth_prog_pkg::ADDR_SETUP: rd_data = {12'h0, setup_cfg};
			synth_prog_pkg::ADDR_AUX: rd_data = {20'h0, aux_divider};
			synth_prog_pkg::ADDR_REF: rd_data = {12'h0, ref_cfg};
			synth_prog_pkg::ADDR_STAT: rd_data = {20'h0, 3'(last_kind_reg),
				hold_pending_reg, frac_acc, integral_pump, speedup, main_standby, aux_standby};
			synth_prog_pkg::ADDR_COUNTS: rd_data = {16'h0, fourth_ratio_count,
				third_ratio_count, second_ratio_count};
			default: rd_ok = 1'b0;
		endcase
	end

	assign s_axi_arready = !s_axi_rvalid;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= synth_prog_pkg::RESP_OKAY;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_data;
			s_axi_rresp <= rd_ok ? synth_prog_pkg::RESP_OKAY : synth_prog_pkg::RESP_SLVERR;
		end
		else if (s_axi_rvalid && s_axi_rready)
		begin
			s_axi_rvalid <= 1'b0;
		end
	end
endmodule // synth_serial_program_port

//--- core/synth_prog_pkg.sv
// Constants, word layouts and register map of the serial programming port
package synth_prog_pkg;
	localparam int CLK_HZ = 40_000_000;
	localparam int LINK_MAX_BPS = 10_000_000;
	localparam int CYCLES_PER_BIT = CLK_HZ / LINK_MAX_BPS;
	localparam int PIN_SCLK = 0;
	localparam int PIN_DATA = 1;
	localparam int PIN_STB = 2;
	localparam int PIN_COUNT = 3;
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_MAIN = 8'h04;
	localparam logic [7:0] ADDR_SETUP = 8'h08;
	localparam logic [7:0] ADDR_AUX = 8'h0c;
	localparam logic [7:0] ADDR_REF = 8'h10;
	localparam logic [7:0] ADDR_STAT = 8'h14;
	localparam logic [7:0] ADDR_COUNTS = 8'h18;
	localparam logic CTRL_EN_RESET = 1'h1;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// Prefixes as they sit in the shift register, last bit received at bit 0
	localparam logic [3:0] PFX_SETUP = 4'h1;
	localparam logic [3:0] PFX_AUX = 4'h9;
	localparam logic [3:0] PFX_REF = 4'h5;
	localparam logic [1:0] MODS_TWO = 2'h0;
	localparam logic [1:0] MODS_THREE = 2'h1;
	localparam logic [1:0] MODS_FOUR = 2'h2;
	localparam logic [3:0] FRAC_MOD5 = 4'h5;
	localparam logic [3:0] FRAC_MOD8 = 4'h8;
	localparam logic [4:0] GAIN_UNITY = 5'h01;
	localparam int SHORT_BITS = 24;
	localparam int LONG_BITS = 32;
	typedef enum {KIND_MAIN, KIND_SETUP, KIND_AUX, KIND_REF, KIND_NONE} kind_e;
	typedef struct packed {
		logic [7:0] second_field;
		logic [11:0] first_ratio_count;
		logic [2:0] frac_increment;
	} main_s;
	typedef struct packed {
		logic [7:0] current_scale;
		main_s body;
		logic lead;
	} main_word_s;
	typedef struct packed {
		logic [1:0] modulus_count_sel;
		logic [1:0] prop_accel;
		logic [3:0] int_accel;
		logic [7:0] current_scale;
		logic [3:0] ratio_sum;
	} setup_s;
	typedef struct packed {
		setup_s body;
		logic [3:0] prefix;
	} setup_word_s;
	typedef struct packed {
		logic [7:0] unused;
		logic [11:0] aux_divider;
		logic [3:0] prefix;
	} aux_word_s;
	typedef struct packed {
		logic long_sel;
		logic frac_modulus_sel;
		logic aux_off;
		logic [1:0] aux_source_sel;
		logic main_off;
		logic [1:0] main_source_sel;
		logic [11:0] ref_divider;
	} ref_s;
	typedef struct packed {
		ref_s body;
		logic [3:0] prefix;
	} ref_word_s;
endpackage

//--- verification/synth_serial_program_port_checker.sv
// Concurrent checks on the programming port outputs
`timescale 1ns/10ps
module synth_serial_program_port_checker #(
	parameter int ADDR_W = 8
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic strobe_pin,
	input wire logic cmp_tick,
	input wire synth_prog_pkg::main_s main_cfg,
	input wire synth_prog_pkg::setup_s setup_cfg,
	input wire synth_prog_pkg::ref_s ref_cfg,
	input wire logic [3:0] main_ref_mult,
	input wire logic speedup,
	input wire logic [4:0] prop_gain,
	input wire logic [4:0] comp_gain,
	input wire logic integral_pump,
	input wire logic integral_cancel_pulse,
	input wire logic [3:0] integral_scale,
	input wire logic [3:0] frac_acc,
	input wire logic ratio_plus_one
);
	logic [4:0] acc_sum;
	logic [4:0] acc_mod;
	logic [4:0] acc_next;
	logic acc_wrap;
	logic [1:0] src_q;
	always_comb
	begin
		acc_sum = {1'b0, frac_acc} + {2'h0, main_cfg.frac_increment};
		acc_mod = ref_cfg.frac_modulus_sel ? 5'h08 : 5'h05;
		acc_wrap = acc_sum >= acc_mod;
		acc_next = acc_wrap ? acc_sum - acc_mod : acc_sum;
		src_q = ref_cfg.main_source_sel;
	end
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	a_gain_idle: assert property (!speedup |=> prop_gain == 5'h01 && comp_gain == 5'h01)
		else $error("gain not unity outside speed-up");
	a_gain_fast: assert property (speedup [*3] |=>
		prop_gain == (5'h02 << setup_cfg.prop_accel) && comp_gain == prop_gain)
		else $error("speed-up gain wrong");
	a_int_idle: assert property (!speedup |=>
		!integral_pump && !integral_cancel_pulse && integral_scale == 4'h0)
		else $error("integral pulses outside speed-up");
	a_int_fast: assert property (speedup [*3] |=>
		integral_pump && integral_scale == setup_cfg.int_accel)
		else $error("integral pump wrong in speed-up");
	a_speed_end: assert property (!strobe_pin [*6] |-> !speedup)
		else $error("speed-up outlives strobe");
	a_speed_start: assert property ($rose(speedup) |-> strobe_pin)
		else $error("speed-up without strobe");
	a_frac_wrap: assert property (cmp_tick |=>
		ratio_plus_one == $past(acc_wrap) && frac_acc == $past(acc_next))
		else $error("accumulator step wrong");
	a_frac_quiet: assert property (!cmp_tick |=> !ratio_plus_one)
		else $error("ratio step without tick");
	a_ref_mult: assert property ($stable(src_q) [*2] |-> main_ref_mult == (4'h1 << src_q))
		else $error("reference multiple wrong");
	c_speedup: cover property ($rose(speedup));
	c_overflow: cover property (ratio_plus_one);
	c_four: cover property (speedup && setup_cfg.modulus_count_sel == 2'h2);
endmodule // synth_serial_program_port_checker

bind synth_serial_program_port synth_serial_program_port_checker #(.ADDR_W(ADDR_W)) chk (
	.aclk, .aresetn, .strobe_pin, .cmp_tick, .main_cfg, .setup_cfg, .ref_cfg, .main_ref_mult,
	.speedup, .prop_gain, .comp_gain, .integral_pump, .integral_cancel_pulse, .integral_scale,
	.frac_acc, .ratio_plus_one
);

//--- verification/serial_host_model.sv
// Host controller model driving the three-wire programming link
`timescale 1ns/10ps
module serial_host_model (
	output logic sclk_pin,
	output logic sdata_pin,
	output logic strobe_pin
);
	localparam int HALF_NS = 100;
	initial
	begin
		sclk_pin = 1'b0;
		sdata_pin = 1'b0;
		strobe_pin = 1'b0;
	end
	// Top bit first, so the lead bit lands last
	task automatic load(input logic [31:0] w, input int n);
		#7;
		for (int i = n - 1; i >= 0; i--)
		begin
			sdata_pin = w[i];
			#HALF_NS sclk_pin = 1'b1;
			#HALF_NS sclk_pin = 1'b0;
		end
		strobe_pin = 1'b1;
		sdata_pin = ~w[0];
	endtask
	task automatic noise(input int k);
		repeat (k)
		begin
			#HALF_NS sclk_pin = 1'b1;
			sdata_pin = ~sdata_pin;
			#HALF_NS sclk_pin = 1'b0;
		end
	endtask
	task automatic release_strobe();
		#HALF_NS strobe_pin = 1'b0;
		#HALF_NS;
	endtask
endmodule // serial_host_model

//--- verification/synth_serial_program_port_tb.sv
// Self-checking bench for the serial programming port
`timescale 1ns/10ps
module synth_serial_program_port_tb;
	logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
	logic s_axi_rready, cmp_tick, sclk_pin, sdata_pin, strobe_pin, main_standby;
	logic aux_standby, speedup, integral_pump, integral_cancel_pulse, ratio_plus_one;
	logic [7:0] s_axi_awaddr, s_axi_araddr, second_ratio_count;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb, main_ref_mult, aux_ref_mult, third_ratio_count;
	logic [3:0] fourth_ratio_count, integral_scale, frac_acc;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [4:0] prop_gain, comp_gain;
	logic [11:0] aux_divider;
	synth_prog_pkg::main_s main_cfg;
	synth_prog_pkg::setup_s setup_cfg;
	synth_prog_pkg::ref_s ref_cfg;
	int num_errors = 0;
	int cmp_count = 0;
	synth_serial_program_port DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .sclk_pin,
		.sdata_pin, .strobe_pin, .cmp_tick, .main_cfg, .setup_cfg, .aux_divider, .ref_cfg,
		.second_ratio_count, .third_ratio_count, .fourth_ratio_count, .main_ref_mult,
		.aux_ref_mult, .main_standby, .aux_standby, .speedup, .prop_gain, .comp_gain,
		.integral_pump, .integral_cancel_pulse, .integral_scale, .frac_acc, .ratio_plus_one);
	serial_host_model host (.sclk_pin, .sdata_pin, .strobe_pin);
	initial
	begin
		aclk = 1'b0;
		forever #12.5 aclk = ~aclk;
	end
	task automatic conclude();
		if (num_errors == 0 && cmp_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		cmp_count++;
		if (g !== e)
		begin
			num_errors++;
			$display("[FAIL] %0t got %h exp %h", $time, g, e);
		end
	endtask
	// One bus transfer; ready and answer sampled mid-cycle, taken at the next edge
	task automatic axi(input logic wr, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic [1:0] r);
		int n;
		logic ta;
		logic tw;
		logic tar;
		logic tr;
		n = 0;
		tr = 1'b0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_awvalid <= wr;
		s_axi_wdata <= d;
		s_axi_wvalid <= wr;
		s_axi_bready <= wr;
		s_axi_araddr <= a;
		s_axi_arvalid <= !wr;
		s_axi_rready <= !wr;
		while (!tr)
		begin
			@(negedge aclk);
			ta = s_axi_awready && s_axi_awvalid;
			tw = s_axi_wready && s_axi_wvalid;
			tar = s_axi_arready && s_axi_arvalid;
			tr = wr ? s_axi_bvalid : s_axi_rvalid;
			q = s_axi_rdata;
			r = wr ? s_axi_bresp : s_axi_rresp;
			@(posedge aclk);
			if (ta) s_axi_awvalid <= 1'b0;
			if (tw) s_axi_wvalid <= 1'b0;
			if (tar) s_axi_arvalid <= 1'b0;
			if (tr) s_axi_bready <= 1'b0;
			if (tr) s_axi_rready <= 1'b0;
			n++;
			if (n > 100)
			begin
				num_errors++;
				$display("[FAIL] %0t bus timeout", $time);
				conclude();
			end
		end
	endtask
	task automatic settle();
		repeat (8) @(posedge aclk);
		@(negedge aclk);
	endtask
	task automatic word(input logic [31:0] w, input int n);
		host.load(w, n);
		settle();
	endtask
	task automatic drop();
		host.release_strobe();
		settle();
	endtask
	task automatic t_reset();
		logic [31:0] q;
		logic [1:0] r;
		chk(main_ref_mult, 4'h1);
		chk({prop_gain, comp_gain}, 10'h021);
		chk({speedup, integral_pump, ratio_plus_one}, 3'h0);
		axi(1'b0, synth_prog_pkg::ADDR_CTRL, 32'h0, q, r);
		chk(q, 32'h1);
		axi(1'b0, 8'h1c, 32'h0, q, r);
		chk(q, 32'h0);
		chk(r, synth_prog_pkg::RESP_SLVERR);
		axi(1'b1, synth_prog_pkg::ADDR_MAIN, 32'h5, q, r);
		chk(r, synth_prog_pkg::RESP_SLVERR);
		axi(1'b0, synth_prog_pkg::ADDR_MAIN, 32'h0, q, r);
		chk(q, 32'h0);
	endtask
	task automatic t_ref();
		logic [23:0] w;
		word({8'h5a, 12'habc, synth_prog_pkg::PFX_AUX}, 24);
		drop();
		chk(aux_divider, 12'habc);
		for (int i = 0; i < 4; i++)
		begin
			w = {1'b0, i[0], i[1], ~i[1:0], ~i[0], i[1:0], 8'h12, i[3:0], synth_prog_pkg::PFX_REF};
			word(w, 24);
			drop();
			chk(ref_cfg, w[23:4]);
			chk(main_ref_mult, 4'h1 << i[1:0]);
			chk(aux_ref_mult, 4'h8 >> i[1:0]);
			chk({main_standby, aux_standby}, {~i[0], i[1]});
		end
	endtask
	task automatic t_modes();
		logic [19:0] s;
		logic [19:0] p;
		p = 20'h0;
		for (int c = 0; c < 3; c++)
		begin
			s = {c[1:0], 2'(c + 1), 4'h4 + c[3:0], 8'h3c, 4'ha};
			word({s, synth_prog_pkg::PFX_SETUP}, 24);
			chk(setup_cfg, p);
			chk(speedup, 1'b0);
			drop();
			word({8'h37, 12'h033, 3'h5, 1'b0}, 24);
			chk(setup_cfg, s);
			chk(main_cfg, {8'h37, 12'h033, 3'h5});
			chk(speedup, 1'b1);
			chk({prop_gain, comp_gain}, {5'h04 << c, 5'h04 << c});
			chk({integral_pump, integral_cancel_pulse, integral_scale}, {2'h3, s[15:12]});
			host.noise(3);
			drop();
			// Re-strobe with no new bits exposes any shift by the noise
			word(32'h0, 0);
			chk(main_cfg, {8'h37, 12'h033, 3'h5});
			drop();
			chk({speedup, integral_pump, prop_gain}, 7'h01);
			chk(second_ratio_count, c == 0 ? 8'h37 : 8'h03);
			if (c > 0) chk(third_ratio_count, 4'h4);
			if (c == 2) chk(fourth_ratio_count, 4'h3);
			p = s;
		end
	endtask
	task automatic t_frac();
		logic [4:0] e;
		logic p;
		for (int m = 0; m < 2; m++)
		begin
			word({1'b1, m[0], 6'h0, 12'h040, synth_prog_pkg::PFX_REF}, 24);
			drop();
			word({8'h77, 8'h12, 12'h0a0, 3'h3, 1'b0}, 32);
			drop();
			chk(setup_cfg.current_scale, 8'h77);
			chk(main_cfg, {8'h12, 12'h0a0, 3'h3});
			e = 5'h0;
			repeat (m ? 8 : 5)
			begin
				@(posedge aclk);
				cmp_tick <= 1'b1;
				@(posedge aclk);
				cmp_tick <= 1'b0;
				e = e + 5'h3;
				p = e >= (m ? 5'h8 : 5'h5);
				if (p) e = e - (m ? 5'h8 : 5'h5);
				@(negedge aclk);
				chk({ratio_plus_one, frac_acc}, {p, e[3:0]});
			end
		end
	endtask
	task automatic t_ctrl();
		logic [31:0] q;
		logic [1:0] r;
		axi(1'b1, synth_prog_pkg::ADDR_CTRL, 32'h0, q, r);
		chk(r, synth_prog_pkg::RESP_OKAY);
		word({8'h0, 12'h123, synth_prog_pkg::PFX_AUX}, 24);
		drop();
		chk(aux_divider, 12'habc);
		axi(1'b1, synth_prog_pkg::ADDR_CTRL, 32'h1, q, r);
		word({8'h0, 12'h123, synth_prog_pkg::PFX_AUX}, 24);
		drop();
		chk(aux_divider, 12'h123);
	endtask
	initial
	begin
		aresetn = 1'b0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
		s_axi_wstrb = 4'hf;
		cmp_tick = 1'b0;
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
		@(negedge aclk);
		t_reset();
		t_ref();
		t_modes();
		t_frac();
		t_ctrl();
		conclude();
	end
endmodule // synth_serial_program_port_tb
